//--- rtl/hwm_regs.svh
// register offsets, field positions, reset values and slot tables of the upper bank
`ifndef HWM_REGS_SVH
`define HWM_REGS_SVH

// vendor test registers that only read back a fixed pattern
`define HWM_ADDR_TEST_73      8'h73
`define HWM_ADDR_TEST_75      8'h75
`define HWM_ADDR_TEST_77      8'h77
`define HWM_ADDR_TEST_7A      8'h7a
`define HWM_ADDR_TEST_89      8'h89
`define HWM_ADDR_TEST_8A      8'h8a
`define HWM_ADDR_TEST_8C      8'h8c
`define HWM_ADDR_TEST_8E      8'h8e
`define HWM_ADDR_TEST_FF      8'hff
`define HWM_RST_TEST_09       8'h09
`define HWM_RST_TEST_00       8'h00
`define HWM_RST_TEST_4D       8'h4d

// conversion low-order nibble registers
`define HWM_ADDR_CONV_DIODES  8'h85
`define HWM_ADDR_CONV_12V_AMB 8'h86
`define HWM_ADDR_CONV_5V_2V5  8'h87
`define HWM_ADDR_CONV_CORE    8'h88

// special function and configuration registers, with their fields
`define HWM_ADDR_SFC          8'h7c
`define HWM_ADDR_CFG          8'h7f
`define HWM_SFC_PIN_IRQ_BIT   2
`define HWM_SFC_LOW_POWER_BIT 0
`define HWM_SFC_SHUTDOWN_MASK 8'h07
`define HWM_SFC_LOCKED_MASK   8'h04
`define HWM_CFG_INIT_BIT      7
`define HWM_CFG_READY_BIT     3

// lock/start/override control, interrupt status and duty cycle registers
`define HWM_ADDR_LOCK_START   8'h40
`define HWM_ADDR_STATUS_BASE  8'h41
`define HWM_ADDR_DUTY_BASE    8'h30
`define HWM_LS_START_BIT      0
`define HWM_LS_LOCK_BIT       1
`define HWM_LS_OVERRIDE_BIT   2
`define HWM_DUTY_RESET        8'h00
`define HWM_UNDEF_READ        8'h00
`define HWM_ADDR_UNDEF_LO     8'h99
`define HWM_ADDR_UNDEF_HI     8'hfe

// read/write slots, slot 0 in the low byte
`define HWM_SLOT_COUNT        22
`define HWM_SLOT_CFG          7
`define HWM_SLOT_SFC          5
`define HWM_SLOT_ADDR  {8'h98, 8'h97, 8'h96, 8'h95, 8'h94, 8'h93, 8'h92, 8'h91, \
   8'h90, 8'h8d, 8'h8b, 8'h82, 8'h81, 8'h80, 8'h7f, 8'h7e, 8'h7c, 8'h7b, 8'h79, \
   8'h78, 8'h76, 8'h74}
`define HWM_SLOT_RESET {8'hf1, 8'h5a, 8'h0c, 8'h0c, 8'h0c, 8'hcc, 8'hcc, 8'hcc, \
   8'hcc, 8'h09, 8'h4d, 8'h0e, 8'ha4, 8'h1e, 8'h10, 8'hec, 8'h40, 8'h00, 8'h00, \
   8'h09, 8'h09, 8'h09}
`define HWM_SLOT_MASK  {8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, \
   8'hff, 8'h1f, 8'h7f, 8'h0f, 8'hff, 8'h1f, 8'hf3, 8'hed, 8'hff, 8'hff, 8'hff, \
   8'h0f, 8'h0f, 8'h0f}
`define HWM_SLOT_LOCKED 22'h3e1fff

`endif

//--- rtl/hwm_pkg.sv
// types shared by the upper register bank and its users
package hwm_pkg;

   // one register access from the serial management front end
   typedef struct packed {
      logic       wr;    // one-cycle write strobe
      logic       rd;    // one-cycle read strobe
      logic [7:0] addr;  // register offset
      logic [7:0] wdata; // write data
   } hwm_req_s;

   // low-order conversion nibbles from the measurement engine
   typedef struct packed {
      logic [3:0] diode2;
      logic [3:0] diode1;
      logic [3:0] v12;
      logic [3:0] ambient;
      logic [3:0] v5;
      logic [3:0] v2p5;
      logic [3:0] vcc;
      logic [3:0] vccp;
   } hwm_conv_s;

endpackage

//--- rtl/hwm_upper_bank.sv
// upper register bank of the fan control and hardware monitor, with access gating
//
// Contract
// - duty write only in manual, not locked
// - lock guards lock/start; override always writable
// - status clears on read if no event
// - pin interrupt enable always writable
// - shutdown blocks all but sfc[2:0], config, lock/start
// - option reserved top bits store, no effect
// - read-only conversion low nibbles, two per register
// - voltage enable layout, reset ech
// - speed enable layout, reset 1eh
// - thermal enable layout, reset 0eh
// - special function layout, reset 40h
// - configuration layout, reset 10h
// - undefined reads 00h, writes ignored
`timescale 1ns/1ns
`include "hwm_regs.svh"

module hwm_upper_bank #(
   parameter int          FANS          = 3,     // fans with a duty register
   parameter int          STATUS_REGS   = 2,     // clear-on-read status registers
   parameter logic [7:0]  TEST_RO_VALUE = 8'h00  // arbitrary value for live test regs
) (
   input  wire logic                        ref_clk_i,
   input  wire logic                        rst_n_i,
   input  wire hwm_pkg::hwm_req_s           req_i,
   input  wire hwm_pkg::hwm_conv_s          conv_low_i,
   input  wire logic [FANS-1:0]             manual_i,
   input  wire logic                        readings_valid_i,
   input  wire logic [STATUS_REGS*8-1:0]    evt_i,
   output logic      [7:0]                  rd_data_o,
   output logic      [`HWM_SLOT_COUNT*8-1:0] slot_o,
   output logic      [FANS*8-1:0]           duty_o,
   output logic                             start_o,
   output logic                             lock_o,
   output logic                             override_o,
   output logic      [STATUS_REGS*8-1:0]    status_o,
   output logic                             setup_reset_o
);

   localparam int N = `HWM_SLOT_COUNT;
   localparam logic [N*8-1:0] SLOT_ADDR  = `HWM_SLOT_ADDR;   // slot offsets
   localparam logic [N*8-1:0] SLOT_RESET = `HWM_SLOT_RESET;  // slot reset values
   localparam logic [N*8-1:0] SLOT_MASK  = `HWM_SLOT_MASK;   // implemented bits
   localparam logic [N-1:0]   SLOT_LOCK  = `HWM_SLOT_LOCKED; // lock attribute

   logic [7:0]  slot [N];          // read/write storage
   logic [N-1:0] slot_hit;         // address matches slot
   logic        shutdown;          // low power select with start clear
   logic        ls_hit;            // lock/start register addressed
   logic [7:0]  next_rd_data;      // read mux output
   logic        cfg_init_wr;       // accepted write of setup-reset

   // shutdown is low-power select set while start is clear
   assign shutdown = slot[`HWM_SLOT_SFC][`HWM_SFC_LOW_POWER_BIT] & ~start_o;
   // lock/start sits outside the slot table so that start can, unless locked,
   // be written to leave shutdown; a slot would be masked with the rest
   assign ls_hit   = (req_i.addr == `HWM_ADDR_LOCK_START);

   // ---------------------------------------------------------------
   // lock, start and manual override
   // ---------------------------------------------------------------

   // lock and start freeze once lock is set; lock only leaves by reset
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         start_o <= 1'b0;
         lock_o  <= 1'b0;
      end else if (req_i.wr && ls_hit && !lock_o) begin
         start_o <= req_i.wdata[`HWM_LS_START_BIT];
         lock_o  <= req_i.wdata[`HWM_LS_LOCK_BIT];
      end
   end

   // override stays writable whatever lock and start say
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         override_o <= 1'b0;
      end else if (req_i.wr && ls_hit) begin
         override_o <= req_i.wdata[`HWM_LS_OVERRIDE_BIT];
      end
   end

   // ---------------------------------------------------------------
   // read/write slots, one generate entry per register
   // ---------------------------------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < N; gi++) begin : g_slot
         logic [7:0] wmask; // bits this write may change

         assign slot_hit[gi] = (req_i.addr == SLOT_ADDR[gi*8 +: 8]);

         // mask shrinks under lock and under shutdown
         always_comb begin
            wmask = SLOT_MASK[gi*8 +: 8];
            if (lock_o && SLOT_LOCK[gi]) begin
               // only the pin interrupt enable survives the lock
               wmask = (gi == `HWM_SLOT_SFC) ? `HWM_SFC_LOCKED_MASK : 8'h00;
            end
            if (shutdown) begin
               if (gi == `HWM_SLOT_SFC) begin
                  wmask = wmask & `HWM_SFC_SHUTDOWN_MASK;
               end else if (gi != `HWM_SLOT_CFG) begin
                  wmask = 8'h00;
               end
            end
         end

         // store writes through the mask; the option register's reserved top bits are plain storage
         always_ff @(posedge ref_clk_i) begin
            if (!rst_n_i) begin
               slot[gi] <= SLOT_RESET[gi*8 +: 8];
            end else if (req_i.wr && slot_hit[gi]) begin
               slot[gi] <= (slot[gi] & ~wmask) | (req_i.wdata & wmask);
            end else if (gi == `HWM_SLOT_CFG) begin
               // setup-reset reads back clear after its pulse
               slot[gi][`HWM_CFG_INIT_BIT] <= 1'b0;
            end
         end

         assign slot_o[gi*8 +: 8] = slot[gi];
      end
   endgenerate

   // accepted setup-reset write, seen by the rest of the device as a pulse
   assign cfg_init_wr = req_i.wr && slot_hit[`HWM_SLOT_CFG] && !(lock_o)
                        && req_i.wdata[`HWM_CFG_INIT_BIT];

   // registered so the pulse lines up with the stored bit
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         setup_reset_o <= 1'b0;
      end else begin
         setup_reset_o <= cfg_init_wr;
      end
   end

   // ---------------------------------------------------------------
   // current duty cycle per fan
   // a fan in automatic mode drops the write
   // ---------------------------------------------------------------
   generate
      for (gi = 0; gi < FANS; gi++) begin : g_duty
         logic hit; // this fan's duty register addressed
         assign hit = (req_i.addr == (`HWM_ADDR_DUTY_BASE + 8'(gi)));

         // start counts only through shutdown; manual mode, lock and shutdown decide
         always_ff @(posedge ref_clk_i) begin
            if (!rst_n_i) begin
               duty_o[gi*8 +: 8] <= `HWM_DUTY_RESET;
            end else if (req_i.wr && hit && manual_i[gi] && !lock_o && !shutdown) begin
               duty_o[gi*8 +: 8] <= req_i.wdata;
            end
         end
      end
   endgenerate

   // ---------------------------------------------------------------
   // clear-on-read interrupt status
   // ---------------------------------------------------------------
   generate
      for (gi = 0; gi < STATUS_REGS; gi++) begin : g_status
         logic hit;      // this status register addressed
         logic clr;      // read with nothing still pending
         assign hit = (req_i.addr == (`HWM_ADDR_STATUS_BASE + 8'(gi)));
         // a still-active event keeps the register; a new event wins over the clear
         assign clr = req_i.rd && hit && !shutdown && (evt_i[gi*8 +: 8] == 8'h00);

         always_ff @(posedge ref_clk_i) begin
            if (!rst_n_i) begin
               status_o[gi*8 +: 8] <= 8'h00;
            end else if (clr) begin
               status_o[gi*8 +: 8] <= 8'h00;
            end else begin
               status_o[gi*8 +: 8] <= status_o[gi*8 +: 8] | evt_i[gi*8 +: 8];
            end
         end
      end
   endgenerate

   // ---------------------------------------------------------------
   // read multiplexer
   // ---------------------------------------------------------------

   // fixed offsets first, then slots, duty and status by search
   always_comb begin
      next_rd_data = `HWM_UNDEF_READ;
      case (req_i.addr)
         `HWM_ADDR_TEST_73, `HWM_ADDR_TEST_75, `HWM_ADDR_TEST_77,
         `HWM_ADDR_TEST_8C:     next_rd_data = `HWM_RST_TEST_09;
         `HWM_ADDR_TEST_7A:     next_rd_data = `HWM_RST_TEST_00;
         `HWM_ADDR_TEST_8A:     next_rd_data = `HWM_RST_TEST_4D;
         `HWM_ADDR_TEST_89, `HWM_ADDR_TEST_8E,
         `HWM_ADDR_TEST_FF:     next_rd_data = TEST_RO_VALUE;
         `HWM_ADDR_CONV_DIODES:  next_rd_data = {conv_low_i.diode2, conv_low_i.diode1};
         `HWM_ADDR_CONV_12V_AMB: next_rd_data = {conv_low_i.v12, conv_low_i.ambient};
         `HWM_ADDR_CONV_5V_2V5:  next_rd_data = {conv_low_i.v5, conv_low_i.v2p5};
         `HWM_ADDR_CONV_CORE:    next_rd_data = {conv_low_i.vcc, conv_low_i.vccp};
         `HWM_ADDR_LOCK_START: begin
            next_rd_data = 8'h00;
            next_rd_data[`HWM_LS_START_BIT]    = start_o;
            next_rd_data[`HWM_LS_LOCK_BIT]     = lock_o;
            next_rd_data[`HWM_LS_OVERRIDE_BIT] = override_o;
         end
         default: begin
            // reserved and undefined offsets keep the zero above
            for (int i = 0; i < N; i++) begin
               if (slot_hit[i]) begin
                  next_rd_data = slot[i];
               end
            end
            for (int i = 0; i < FANS; i++) begin
               if (req_i.addr == (`HWM_ADDR_DUTY_BASE + 8'(i))) begin
                  next_rd_data = duty_o[i*8 +: 8];
               end
            end
            for (int i = 0; i < STATUS_REGS; i++) begin
               if (req_i.addr == (`HWM_ADDR_STATUS_BASE + 8'(i))) begin
                  next_rd_data = status_o[i*8 +: 8];
               end
            end
         end
      endcase
      // the ready flag is live status, not storage
      if (slot_hit[`HWM_SLOT_CFG]) begin
         next_rd_data[`HWM_CFG_READY_BIT] = readings_valid_i;
      end
      // in shutdown only the low special-function bits, config and lock/start answer
      if (shutdown && !ls_hit) begin
         if (slot_hit[`HWM_SLOT_SFC]) begin
            next_rd_data = next_rd_data & `HWM_SFC_SHUTDOWN_MASK;
         end else if (!slot_hit[`HWM_SLOT_CFG]) begin
            next_rd_data = 8'h00;
         end
      end
   end

   // read data is captured on the read strobe and holds until the next read
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         rd_data_o <= 8'h00;
      end else if (req_i.rd) begin
         rd_data_o <= next_rd_data;
      end
   end

   // ---------------------------------------------------------------
   // checks
   // one clock, quiet in reset; antecedents are host accesses, except a_lock_sticky, a_setup_clear and a_status_collect,
   // consequents are what this block drives
   // ---------------------------------------------------------------

   // lock only leaves by reset
   a_lock_sticky: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      lock_o |=> lock_o)
      else $error("lock bit dropped without reset");

   // start frozen under lock
   a_lock_start_guard: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      (lock_o && req_i.wr && ls_hit) |=> $stable(start_o))
      else $error("start changed while locked");

   // override written whatever lock says
   a_override_open: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      (req_i.wr && ls_hit) |=> (override_o == $past(req_i.wdata[`HWM_LS_OVERRIDE_BIT])))
      else $error("override write lost");

   // pin enable written whatever lock and shutdown say
   a_pin_irq_open: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      (req_i.wr && slot_hit[`HWM_SLOT_SFC]) |=>
      (slot[`HWM_SLOT_SFC][`HWM_SFC_PIN_IRQ_BIT] == $past(req_i.wdata[`HWM_SFC_PIN_IRQ_BIT])))
      else $error("pin interrupt enable write lost");

   // voltage enables frozen under lock
   a_locked_frozen: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      (lock_o && req_i.wr && slot_hit[6]) |=> $stable(slot[6]))
      else $error("locked register changed");

   // duty refused outside manual or under lock
   a_duty_gate: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      (req_i.wr && req_i.addr == `HWM_ADDR_DUTY_BASE && (!manual_i[0] || lock_o))
      |=> $stable(duty_o[7:0]))
      else $error("duty accepted outside manual or under lock");

   // an active event keeps status across a read
   a_status_keep: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      (req_i.rd && req_i.addr == `HWM_ADDR_STATUS_BASE && evt_i[7:0] != 8'h00)
      |=> (status_o[7:0] != 8'h00))
      else $error("status cleared with an active event");

   // a quiet read clears, then events collect again
   a_status_clear: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      (req_i.rd && req_i.addr == `HWM_ADDR_STATUS_BASE && evt_i[7:0] == 8'h00 && !shutdown)
      |=> (status_o[7:0] == 8'h00) ##1 (status_o[7:0] == $past(evt_i[7:0])))
      else $error("status not cleared on idle read");

   // voltage enables frozen in shutdown
   a_shutdown_block: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      (shutdown && req_i.wr && slot_hit[6]) |=> $stable(slot[6]))
      else $error("monitoring register written in shutdown");

   // undefined space reads zero
   a_undef_zero: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      (req_i.rd && req_i.addr inside {[`HWM_ADDR_UNDEF_LO:`HWM_ADDR_UNDEF_HI]})
      |=> (rd_data_o == `HWM_UNDEF_READ))
      else $error("undefined offset read not zero");

   // conversion nibbles read live
   a_conv_read: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      (req_i.rd && req_i.addr == `HWM_ADDR_CONV_DIODES && !shutdown)
      |=> (rd_data_o == {$past(conv_low_i.diode2), $past(conv_low_i.diode1)}))
      else $error("diode low nibbles misread");

   // option top bits are plain storage
   a_option_rsvd: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      (req_i.wr && slot_hit[17] && !lock_o && !shutdown)
      |=> (slot[17][7:6] == $past(req_i.wdata[7:6])))
      else $error("option reserved bits not stored");

   // accepted setup-reset pulses and shows the bit
   a_setup_pulse: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      (req_i.wr && slot_hit[`HWM_SLOT_CFG] && !lock_o && req_i.wdata[`HWM_CFG_INIT_BIT])
      |=> (setup_reset_o && slot[`HWM_SLOT_CFG][`HWM_CFG_INIT_BIT]))
      else $error("setup-reset write did not pulse");

   // without a fresh write setup-reset reads clear
   a_setup_clear: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      !(req_i.wr && slot_hit[`HWM_SLOT_CFG]) |=> !slot[`HWM_SLOT_CFG][`HWM_CFG_INIT_BIT])
      else $error("setup-reset bit stuck");

   // manual, unlocked fan takes the duty, started or not
   a_duty_open: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      (req_i.wr && req_i.addr == `HWM_ADDR_DUTY_BASE && manual_i[0] && !lock_o && !shutdown)
      |=> (duty_o[7:0] == $past(req_i.wdata)))
      else $error("duty write lost in manual mode");

   // ready flag reads the live input
   a_ready_live: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      (req_i.rd && slot_hit[`HWM_SLOT_CFG])
      |=> (rd_data_o[`HWM_CFG_READY_BIT] == $past(readings_valid_i)))
      else $error("ready flag misread");

   // monitoring registers read zero in shutdown
   a_shutdown_read: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      (shutdown && req_i.rd && slot_hit[6]) |=> (rd_data_o == 8'h00))
      else $error("monitoring register readable in shutdown");

   // only low special-function bits answer in shutdown
   a_sfc_low_read: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      (shutdown && req_i.rd && slot_hit[`HWM_SLOT_SFC])
      |=> ((rd_data_o & ~`HWM_SFC_SHUTDOWN_MASK) == 8'h00))
      else $error("upper special-function bits readable in shutdown");

   // under lock only the pin enable moves
   a_locked_sfc: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      (lock_o && req_i.wr && slot_hit[`HWM_SLOT_SFC])
      |=> ((slot[`HWM_SLOT_SFC] & ~`HWM_SFC_LOCKED_MASK)
           == ($past(slot[`HWM_SLOT_SFC]) & ~`HWM_SFC_LOCKED_MASK)))
      else $error("locked special-function bits changed");

   // speed-input options have no lock attribute
   a_option_open: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      (lock_o && req_i.wr && slot_hit[13] && !shutdown) |=> (slot[13] == $past(req_i.wdata)))
      else $error("unlocked option register refused a write");

   // events collect until a clearing read
   a_status_collect: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      !(req_i.rd && req_i.addr == `HWM_ADDR_STATUS_BASE)
      |=> (status_o[7:0] == ($past(status_o[7:0]) | $past(evt_i[7:0]))))
      else $error("status byte lost an event");

endmodule

//--- verif/hwm_host_model.sv
// host-side model that issues single register accesses to the upper bank
`timescale 1ns/1ns
module hwm_host_model (
   input  wire logic         ref_clk_i,
   input  wire logic [7:0]   rd_data_i,
   output hwm_pkg::hwm_req_s req_o
);
   // idle request: strobes low
   initial req_o = '0;

   // released lines show the inverse, so a stale address is not left on the bus
   task automatic release_bus();
      req_o.wr = 1'b0;
      req_o.rd = 1'b0;
      req_o.addr = ~req_o.addr;
      req_o.wdata = ~req_o.wdata;
   endtask

   // one-cycle write strobe, launched just after an edge
   task automatic host_write(input logic [7:0] addr, input logic [7:0] data);
      logic [7:0] val;
      val = data;
      // the host keeps out of vendor test space
      if (addr inside {[8'h73:8'h7b], [8'h89:8'h8e], 8'h97, 8'h98, 8'hff}) return;
      // vendor bits always go back at their defaults
      if (addr == 8'h7c) val[4:3] = 2'b00;
      if (addr == 8'h7f) val[6:5] = 2'b00;
      @(posedge ref_clk_i);
      #1;
      req_o.wr = 1'b1;
      req_o.addr = addr;
      req_o.wdata = val;
      @(posedge ref_clk_i);
      #1;
      release_bus();
   endtask

   // one-cycle read strobe; data is taken a full cycle later, where it has settled
   task automatic host_read(input logic [7:0] addr, output logic [7:0] data);
      @(posedge ref_clk_i);
      #1;
      req_o.rd = 1'b1;
      req_o.addr = addr;
      @(posedge ref_clk_i);
      #1;
      release_bus();
      @(posedge ref_clk_i);
      #1;
      data = rd_data_i;
   endtask
endmodule

//--- verif/tb_top.sv
// self-checking bench for the upper register bank
`timescale 1ns/1ns
module tb_top;
   logic                ref_clk_i;        // 50 MHz clock
   logic                rst_n_i;          // synchronous reset, active low
   hwm_pkg::hwm_req_s   req;              // request from the host model
   hwm_pkg::hwm_conv_s  conv_low;         // low-order conversion nibbles
   logic [2:0]          manual;           // per-fan manual mode
   logic                readings_valid;   // live ready flag
   logic [15:0]         evt;              // status events
   logic [7:0]          rd_data;          // read data
   logic [175:0]        slot;             // storage slots
   logic [23:0]         duty;             // duty cycles
   logic                start;            // start bit
   logic                lock;             // lock bit
   logic                override;         // manual override bit
   logic [15:0]         status;           // sticky status
   logic                setup_reset;      // setup-reset pulse
   int                  num_errors = 0;   // mismatches
   int                  compares = 0;     // comparisons made
   int                  pulses = 0;       // setup-reset pulses seen

   // address/value pairs checked straight after reset
   localparam logic [15:0] RST_TAB [36] = '{16'h7309, 16'h7409, 16'h7509, 16'h7609,
      16'h7709, 16'h7809, 16'h7900, 16'h7a00, 16'h7b00, 16'h7c40, 16'h7d00, 16'h7eec,
      16'h7f10, 16'h801e, 16'h81a4, 16'h820e, 16'h8300, 16'h8400, 16'h8a4d, 16'h8b4d,
      16'h8c09, 16'h8d09, 16'h8f00, 16'h90cc, 16'h93cc, 16'h940c, 16'h960c, 16'h975a,
      16'h98f1, 16'ha000, 16'hfe00, 16'hff00, 16'h4000, 16'h3000, 16'h4100, 16'h4200};

   hwm_host_model u_hwm_host_model (.ref_clk_i(ref_clk_i), .rd_data_i(rd_data), .req_o(req));

   hwm_upper_bank #(.FANS(3), .STATUS_REGS(2), .TEST_RO_VALUE(8'h00)) u_hwm_upper_bank (
      .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .req_i(req), .conv_low_i(conv_low),
      .manual_i(manual), .readings_valid_i(readings_valid), .evt_i(evt),
      .rd_data_o(rd_data), .slot_o(slot), .duty_o(duty), .start_o(start), .lock_o(lock),
      .override_o(override), .status_o(status), .setup_reset_o(setup_reset));

   // clock generation
   initial begin
      ref_clk_i = 1'b0;
      forever #10 ref_clk_i = ~ref_clk_i;
   end

   // count setup-reset pulses edge by edge
   always @(posedge ref_clk_i) begin
      if (setup_reset === 1'b1) pulses++;
   end

   task automatic check(input logic [7:0] got, input logic [7:0] exp, input logic [7:0] tag);
      compares++;
      if (got !== exp) begin
         num_errors++;
         $display("Error at %0t: item %h got %h expected %h", $time, tag, got, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      u_hwm_host_model.host_write(a, d);
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
      logic [7:0] d;
      u_hwm_host_model.host_read(a, d);
      check(d, e, a);
   endtask

   // reset held for 8 cycles, released just after an edge
   task automatic do_reset();
      rst_n_i = 1'b0;
      repeat (8) @(posedge ref_clk_i);
      #1;
      rst_n_i = 1'b1;
   endtask

   task automatic report_and_stop();
      if (num_errors == 0 && compares > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   // watchdog: a hang counts as a mismatch
   initial begin
      #2000000;
      num_errors++;
      report_and_stop();
   end

   initial begin
      conv_low = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8};
      manual = 3'b001;
      readings_valid = 1'b0;
      evt = 16'h0000;
      do_reset();
      // reset values, reserved and undefined space
      foreach (RST_TAB[i]) begin
         rd_chk(RST_TAB[i][15:8], RST_TAB[i][7:0]);
      end
      // low-order conversion nibbles, writes ignored
      wr(8'h85, 8'hff);
      rd_chk(8'h85, 8'h12);
      rd_chk(8'h86, 8'h34);
      rd_chk(8'h87, 8'h56);
      rd_chk(8'h88, 8'h78);
      // field masks of the enable and control registers
      wr(8'h7e, 8'hff);
      rd_chk(8'h7e, 8'hed);
      check(slot[55:48], 8'hed, 8'h7e);
      wr(8'h80, 8'hff);
      rd_chk(8'h80, 8'h1f);
      wr(8'h82, 8'hff);
      rd_chk(8'h82, 8'h0f);
      wr(8'h7c, 8'he6);
      rd_chk(8'h7c, 8'he6);
      wr(8'h94, 8'hcc);
      rd_chk(8'h94, 8'hcc);
      wr(8'h7f, 8'h13);
      readings_valid = 1'b1;
      rd_chk(8'h7f, 8'h1b);
      check(slot[63:56], 8'h13, 8'h7f);
      // setup-reset pulses once and self-clears
      wr(8'h7f, 8'h93);
      repeat (3) @(posedge ref_clk_i);
      check(8'(pulses), 8'h01, 8'h7f);
      rd_chk(8'h7f, 8'h1b);
      // undefined and reserved writes vanish
      wr(8'ha0, 8'h5a);
      rd_chk(8'ha0, 8'h00);
      wr(8'h7d, 8'h5a);
      rd_chk(8'h7d, 8'h00);
      // shutdown: only sfc[2:0], config and lock/start stay reachable
      wr(8'h7c, 8'h41);
      rd_chk(8'h7c, 8'h01);
      rd_chk(8'h7e, 8'h00);
      wr(8'h7e, 8'h00);
      wr(8'h7c, 8'hfd);
      rd_chk(8'h7c, 8'h05);
      rd_chk(8'h7f, 8'h1b);
      wr(8'h7c, 8'h00);
      rd_chk(8'h7c, 8'h40);
      rd_chk(8'h7e, 8'hed);
      // duty writes: manual fan only, also while started
      wr(8'h30, 8'h55);
      wr(8'h31, 8'h66);
      rd_chk(8'h30, 8'h55);
      rd_chk(8'h31, 8'h00);
      wr(8'h40, 8'h01);
      wr(8'h30, 8'h77);
      rd_chk(8'h30, 8'h77);
      // status clears on read only once its event is gone
      evt = 16'h0001;
      rd_chk(8'h41, 8'h01);
      rd_chk(8'h41, 8'h01);
      @(posedge ref_clk_i);
      #1;
      evt = 16'h0000;
      rd_chk(8'h41, 8'h01);
      rd_chk(8'h41, 8'h00);
      check(status[7:0], 8'h00, 8'h41);
      // lock: start/lock frozen, override and pin enable still writable
      wr(8'h40, 8'h03);
      wr(8'h40, 8'h04);
      rd_chk(8'h40, 8'h07);
      check({5'h00, override, lock, start}, 8'h07, 8'h40);
      wr(8'h7e, 8'h00);
      rd_chk(8'h7e, 8'hed);
      wr(8'h90, 8'h11);
      rd_chk(8'h90, 8'h11);
      wr(8'h7c, 8'hff);
      rd_chk(8'h7c, 8'h44);
      wr(8'h30, 8'h99);
      rd_chk(8'h30, 8'h77);
      check(duty[7:0], 8'h77, 8'h30);
      // only a reset lifts the lock
      do_reset();
      rd_chk(8'h40, 8'h00);
      wr(8'h7e, 8'h00);
      rd_chk(8'h7e, 8'h00);
      report_and_stop();
   end
endmodule
